// ==== hdl/hdm_defs.svh ====
// register offsets, field positions, reset values and timing counts of the distortion monitor
`ifndef HDM_DEFS_SVH
`define HDM_DEFS_SVH

`define HDM_OFF_CTRL 12'h000
`define HDM_OFF_STAT 12'h004
`define HDM_OFF_IRQ_STAT 12'h008
`define HDM_OFF_IRQ_MASK 12'h00C
`define HDM_OFF_EVT_CNT 12'h010
`define HDM_OFF_TIME 12'h014
`define HDM_OFF_SET_BASE 12'h100
`define HDM_SET_WIN_MASK 12'hF80

`define HDM_CTRL_MODE 0
`define HDM_CTRL_EN_LO 1
`define HDM_CTRL_EN_HI 3
`define HDM_CTRL_CLR 4

`define HDM_MODE_RST 1'h0
`define HDM_EN_RST 3'h7
`define HDM_MASK_RST 9'h000
`define HDM_SET_RST 32'h006403E8

`define HDM_MS_NS 1000000
`define HDM_CLK_NS 8
`define HDM_MS_CYC (`HDM_MS_NS / `HDM_CLK_NS)

`define HDM_SCALE_POW 27'h0002710
`define HDM_SCALE_AMP 27'h5F5E100
`define HDM_REL_NUM_POW 14'h0064
`define HDM_REL_DEN_POW 14'h0061
`define HDM_REL_NUM_AMP 14'h2710
`define HDM_REL_DEN_AMP 14'h24C1

`define HDM_DC_IDX 5'h00
`define HDM_FUND_IDX 5'h01
`define HDM_HARM_LAST 5'h1F
`define HDM_NUM_CHAN 3'h5

`endif

// ==== hdl/hdm_pkg.sv ====
// types shared by the distortion monitor modules
package hdm_pkg;

  typedef enum logic {amplitude_ratio_distortion, power_ratio_distortion} hdm_mode_t;

  typedef struct packed {
    logic start;
    logic alarm;
    logic blocked;
    logic [15:0] dly_cnt;
    logic [15:0] dly_set;
  } hdm_grp_t;

  typedef struct packed {
    hdm_mode_t mode;
    logic [2:0] en;
    logic [8:0] irq_mask;
    logic [8:0] irq_stat;
    logic [31:0] evt_cnt;
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] ms_cnt;
    logic [39:0] acc;
    logic [31:0] den;
    logic [39:0] num;
    logic [31:0] nden;
    logic [2:0] ch;
    logic eval;
    logic [4:0] over;
    hdm_grp_t [2:0] grp;
    logic [8:0] outs_prev;
    logic [8:0] rep;
    logic evt_valid;
    logic [3:0] evt_id;
    logic evt_on;
    logic [31:0] evt_stamp;
    logic ack;
    logic [31:0] rdata;
  } hdm_state_t;

  typedef struct packed {
    logic [31:0][31:0] word;
    logic [31:0] a_rd;
    logic [31:0] b_rd;
  } hdm_mem_st_t;

endpackage : hdm_pkg

// ==== hdl/hdm_mem_if.sv ====
// interface between the monitor core and its setting-set memory
interface hdm_mem_if #(parameter int AW = 5, parameter int DW = 32);
  logic a_en;
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_en;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_rdata;
  modport ctl (output a_en, a_we, a_addr, a_wdata, b_en, b_addr, input a_rdata, b_rdata);
  modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_addr, output a_rdata, b_rdata);
endinterface : hdm_mem_if

// ==== hdl/hdm_setmem.sv ====
// eight setting sets of four words, with registered read ports
`include "hdm_defs.svh"
module hdm_setmem #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access ports
  hdm_mem_if.mem port
);
  import hdm_pkg::*;

  hdm_mem_st_t st_ff;
  hdm_mem_st_t nxt_st;

  if (AW != 5 || DW != 32) begin : g_chk
    $error("hdm_setmem supports AW=5 and DW=32 only");
  end

  always_comb begin
    nxt_st = st_ff;
    if (port.a_en && port.a_we) begin
      nxt_st.word[port.a_addr] = port.a_wdata;
    end
    if (port.a_en && !port.a_we) begin
      nxt_st.a_rd = st_ff.word[port.a_addr];
    end
    if (port.b_en) begin
      nxt_st.b_rd = st_ff.word[port.b_addr];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= {{32{`HDM_SET_RST}}, 32'h00000000, 32'h00000000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port.a_rdata = st_ff.a_rd;
  assign port.b_rdata = st_ff.b_rd;

  AST_MEM_WRITE_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    port.a_en && port.a_we |=> st_ff.word[$past(port.a_addr)] == $past(port.a_wdata))
    else $error("setting word not stored");
endmodule : hdm_setmem

// ==== hdl/hdm_top.sv ====
// harmonic distortion monitor: apb registers, ratio compare, start/alarm/blocked logic, events
`include "hdm_defs.svh"
// Function
// - monitor five channels, harmonics up to 31st
// - power ratio: harmonic power over fundamental power
// - selectable power or amplitude (root) ratio
// - start, alarm, blocked per channel group
// - eight setting sets, one common selector
// - delay setting and blocking applied only when alarming enabled, limit compare runs always
// - time-stamped on/off event per output, 1 ms
// - cumulative start/alarm/blocked counter, software clearable
// - one method setting for all channels
// - pick up when distortion exceeds limit
// - release below 97 percent of limit
// - blocking at pick-up gives blocked, not start
module hdm_top #(
  parameter int MAG_W = 16,
  parameter int MS_CYC = `HDM_MS_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // harmonic spectrum stream
  input wire logic spec_valid,
  input wire logic [2:0] spec_chan,
  input wire logic [4:0] spec_idx,
  input wire logic [MAG_W-1:0] spec_mag,
  // setting set selector and blocking
  input wire logic [2:0] set_sel,
  input wire logic block_in,
  // {blocked, alarm, start} per group
  output logic [2:0] phase_distortion_outputs,
  output logic [2:0] residual_one_distortion_outputs,
  output logic [2:0] residual_two_distortion_outputs,
  // event stream
  output logic evt_valid,
  output logic [3:0] evt_id,
  output logic evt_on,
  output logic [31:0] evt_stamp,
  // interrupt
  output logic irq
);
  import hdm_pkg::*;

  if (MAG_W < 1 || MAG_W > 16 || MS_CYC < 1) begin : g_chk
    $error("hdm_top: MAG_W must be 1..16 and MS_CYC at least 1");
  end

  hdm_state_t st_ff;
  hdm_state_t nxt_st;
  hdm_mem_if #(.AW(5), .DW(32)) mif ();

  hdm_setmem #(.AW(5), .DW(32)) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .port(mif.mem)
  );

  logic apb_acc;
  logic apb_fin;
  logic is_mem;
  logic reg_hit;
  logic wr_ok;
  logic wr_reg;
  logic clr_cnt;
  logic [31:0] rd_mux;
  logic [8:0] outs;
  logic [8:0] rises;
  logic [8:0] diff;
  logic [31:0] sq;
  logic [1:0] word_sel;
  logic [15:0] lim;
  logic [31:0] gain;
  logic [26:0] scale;
  logic [13:0] rel_num;
  logic [13:0] rel_den;
  logic [95:0] lhs;
  logic [95:0] rhs;
  logic pick;
  logic rel;
  logic [1:0] eval_grp;
  logic [2:0] grp_pu;

  // every access takes one wait state so read data can come from flops or memory
  assign apb_acc = psel && penable;
  assign apb_fin = apb_acc && st_ff.ack;
  assign pready = apb_fin;
  // a misaligned window access is refused and must not touch the memory
  assign is_mem = (paddr & `HDM_SET_WIN_MASK) == `HDM_OFF_SET_BASE && paddr[1:0] == 2'h0;
  assign wr_ok = pstrb == 4'hF;
  assign wr_reg = apb_fin && pwrite && wr_ok;
  assign clr_cnt = wr_reg && paddr == `HDM_OFF_CTRL && pwdata[`HDM_CTRL_CLR];
  always_comb begin
    unique case (paddr)
      `HDM_OFF_CTRL, `HDM_OFF_STAT, `HDM_OFF_IRQ_STAT, `HDM_OFF_IRQ_MASK, `HDM_OFF_EVT_CNT,
      `HDM_OFF_TIME: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end
  assign pslverr = apb_fin && (paddr[1:0] != 2'h0 || !(is_mem || reg_hit) || (pwrite && !wr_ok));
  assign prdata = is_mem ? mif.a_rdata : st_ff.rdata;

  always_comb begin
    unique case (paddr)
      `HDM_OFF_CTRL: rd_mux = {28'h0000000, st_ff.en, st_ff.mode};
      `HDM_OFF_STAT: rd_mux = {18'h00000, st_ff.over, outs};
      `HDM_OFF_IRQ_STAT: rd_mux = {23'h000000, st_ff.irq_stat};
      `HDM_OFF_IRQ_MASK: rd_mux = {23'h000000, st_ff.irq_mask};
      `HDM_OFF_EVT_CNT: rd_mux = st_ff.evt_cnt;
      `HDM_OFF_TIME: rd_mux = st_ff.ms_cnt;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // apb port of the setting memory: reads issue in the first access cycle, writes at completion
  assign mif.a_en = is_mem && apb_acc && (pwrite ? (st_ff.ack && wr_ok) : !st_ff.ack);
  assign mif.a_we = pwrite;
  assign mif.a_addr = paddr[6:2];
  assign mif.a_wdata = pwdata;

  // engine port: active set word of the channel that just finished its spectrum
  assign word_sel = (spec_chan < 3'h3) ? 2'h0 : 2'(spec_chan - 3'h2);
  assign mif.b_en = spec_valid && spec_idx == `HDM_HARM_LAST;
  assign mif.b_addr = {set_sel, word_sel};

  // distortion compare, squared form so the amplitude root is never taken
  assign sq = 32'(spec_mag) * 32'(spec_mag);
  assign lim = mif.b_rdata[15:0];
  always_comb begin
    if (st_ff.mode == amplitude_ratio_distortion) begin
      gain = 32'(lim) * 32'(lim);
      scale = `HDM_SCALE_AMP;
      rel_num = `HDM_REL_NUM_AMP;
      rel_den = `HDM_REL_DEN_AMP;
    end else begin
      gain = 32'(lim);
      scale = `HDM_SCALE_POW;
      rel_num = `HDM_REL_NUM_POW;
      rel_den = `HDM_REL_DEN_POW;
    end
  end
  assign lhs = 96'(st_ff.num) * 96'(scale);
  assign rhs = 96'(gain) * 96'(st_ff.nden);
  assign pick = st_ff.nden != 32'h00000000 && lhs > rhs;
  assign rel = st_ff.nden == 32'h00000000 || lhs * 96'(rel_num) < rhs * 96'(rel_den);
  assign eval_grp = (st_ff.ch < 3'h3) ? 2'h0 : 2'(st_ff.ch - 3'h2);
  assign grp_pu = {st_ff.over[4], st_ff.over[3], |st_ff.over[2:0]};

  for (genvar g = 0; g < 3; g++) begin : g_outs
    assign outs[3*g+:3] = {st_ff.grp[g].blocked, st_ff.grp[g].alarm, st_ff.grp[g].start};
  end
  assign rises = outs & ~st_ff.outs_prev;
  assign diff = outs ^ st_ff.rep;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.evt_valid = 1'b0;
    nxt_st.eval = 1'b0;
    nxt_st.tick = 1'b0;
    // millisecond divider for the time stamp and the alarm delay
    if (st_ff.tick_cnt == 32'(MS_CYC - 1)) begin
      nxt_st.tick_cnt = 32'h00000000;
      nxt_st.tick = 1'b1;
      nxt_st.ms_cnt = st_ff.ms_cnt + 32'h00000001;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h00000001;
    end
    // apb
    nxt_st.ack = apb_acc && !st_ff.ack;
    if (apb_acc && !st_ff.ack) begin
      nxt_st.rdata = rd_mux;
    end
    if (wr_reg && paddr == `HDM_OFF_CTRL) begin
      nxt_st.mode = hdm_mode_t'(pwdata[`HDM_CTRL_MODE]);
      nxt_st.en = pwdata[`HDM_CTRL_EN_HI:`HDM_CTRL_EN_LO];
    end
    if (wr_reg && paddr == `HDM_OFF_IRQ_MASK) begin
      nxt_st.irq_mask = pwdata[8:0];
    end
    // read clears only the bits it reported, so an event during the access is kept
    if (apb_fin && !pwrite && paddr == `HDM_OFF_IRQ_STAT) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~st_ff.rdata[8:0];
    end
    nxt_st.irq_stat = nxt_st.irq_stat | rises;
    nxt_st.evt_cnt = (clr_cnt ? 32'h00000000 : st_ff.evt_cnt) + 32'($countones(rises));
    // spectrum accumulation: index 0 is dc, 1 the fundamental, 2..31 the harmonics
    if (spec_valid) begin
      if (spec_idx == `HDM_DC_IDX) begin
        nxt_st.acc = 40'h0000000000;
      end else if (spec_idx == `HDM_FUND_IDX) begin
        nxt_st.den = sq;
      end else begin
        nxt_st.acc = st_ff.acc + 40'(sq);
      end
      if (spec_idx == `HDM_HARM_LAST) begin
        nxt_st.num = st_ff.acc + 40'(sq);
        nxt_st.nden = st_ff.den;
        nxt_st.ch = spec_chan;
        nxt_st.eval = spec_chan < `HDM_NUM_CHAN;
      end
    end
    // per-channel pick-up with hysteresis
    if (st_ff.eval) begin
      if (pick) begin
        nxt_st.over[st_ff.ch] = 1'b1;
      end else if (rel) begin
        nxt_st.over[st_ff.ch] = 1'b0;
      end
      if (st_ff.en[eval_grp]) begin
        nxt_st.grp[eval_grp].dly_set = mif.b_rdata[31:16];
      end
    end
    // group start, alarm and blocked
    for (int g = 0; g < 3; g++) begin
      if (!st_ff.en[g] || !grp_pu[g]) begin
        nxt_st.grp[g].start = 1'b0;
        nxt_st.grp[g].alarm = 1'b0;
        nxt_st.grp[g].blocked = 1'b0;
        nxt_st.grp[g].dly_cnt = 16'h0000;
      end else if (block_in || st_ff.grp[g].blocked) begin
        nxt_st.grp[g].start = 1'b0;
        nxt_st.grp[g].alarm = 1'b0;
        nxt_st.grp[g].blocked = 1'b1;
        nxt_st.grp[g].dly_cnt = 16'h0000;
      end else begin
        nxt_st.grp[g].start = 1'b1;
        if (st_ff.grp[g].start && st_ff.tick && st_ff.grp[g].dly_cnt != 16'hFFFF) begin
          nxt_st.grp[g].dly_cnt = st_ff.grp[g].dly_cnt + 16'h0001;
        end
        nxt_st.grp[g].alarm = st_ff.grp[g].start && nxt_st.grp[g].dly_cnt >= st_ff.grp[g].dly_set;
      end
    end
    nxt_st.outs_prev = outs;
    // one event per cycle, lowest changed output first
    for (int i = 8; i >= 0; i--) begin
      if (diff[i]) begin
        nxt_st.evt_id = 4'(i);
      end
    end
    if (diff != 9'h000) begin
      nxt_st.evt_valid = 1'b1;
      nxt_st.evt_on = outs[nxt_st.evt_id];
      nxt_st.evt_stamp = st_ff.ms_cnt;
      nxt_st.rep[nxt_st.evt_id] = outs[nxt_st.evt_id];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.mode <= hdm_mode_t'(`HDM_MODE_RST);
      st_ff.en <= `HDM_EN_RST;
      st_ff.irq_mask <= `HDM_MASK_RST;
      for (int g = 0; g < 3; g++) begin
        st_ff.grp[g].dly_set <= 16'(`HDM_SET_RST >> 16);
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase_distortion_outputs = outs[2:0];
  assign residual_one_distortion_outputs = outs[5:3];
  assign residual_two_distortion_outputs = outs[8:6];
  assign evt_valid = st_ff.evt_valid;
  assign evt_id = st_ff.evt_id;
  assign evt_on = st_ff.evt_on;
  assign evt_stamp = st_ff.evt_stamp;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ALARM_NEEDS_START: assert property (
    $rose(phase_distortion_outputs[1]) |-> $past(phase_distortion_outputs[0], 1) && phase_distortion_outputs[0])
    else $error("phase alarm without held start");
  AST_START_BLOCKED_EXCL: assert property (
    !(residual_two_distortion_outputs[0] && residual_two_distortion_outputs[2]))
    else $error("start and blocked together");
  AST_BLOCK_DROPS_START: assert property (
    residual_two_distortion_outputs[0] && block_in |=>
      !residual_two_distortion_outputs[0] && !residual_two_distortion_outputs[1])
    else $error("start survived blocking");
  AST_DISABLED_QUIET: assert property (
    !st_ff.en[0] |=> phase_distortion_outputs == 3'h0)
    else $error("disabled group still active");
  AST_EVENT_FOLLOWS: assert property (
    $rose(phase_distortion_outputs[0]) |-> ##[1:9] (evt_valid && evt_on && evt_id == 4'h0))
    else $error("start rise not reported");
  AST_COUNT_CLEARED: assert property (
    clr_cnt |=> st_ff.evt_cnt <= 32'h00000009)
    else $error("event counter not cleared");
  AST_PICKUP: assert property (
    st_ff.eval && pick |=> st_ff.over[$past(st_ff.ch)])
    else $error("no pick-up above limit");
  AST_RELEASE: assert property (
    st_ff.eval && !pick && rel |=> !st_ff.over[$past(st_ff.ch)])
    else $error("no release below 97 percent");
  AST_HOLD_BAND: assert property (
    st_ff.eval && !pick && !rel |=> $stable(st_ff.over))
    else $error("state changed inside hysteresis band");
  AST_LAST_HARMONIC: assert property (
    spec_valid && spec_idx == `HDM_HARM_LAST && spec_chan < `HDM_NUM_CHAN |=> st_ff.eval)
    else $error("channel end not evaluated");
  AST_IRQ_LEVEL: assert property (
    $rose(phase_distortion_outputs[0]) && st_ff.irq_mask[0] |=> irq)
    else $error("interrupt missing");
endmodule : hdm_top

// ==== dv/hdm_spec_src.sv ====
// upstream spectrum source model: one 32-sample frame per call
module hdm_spec_src (
  // clock
  input wire logic pclk,
  // spectrum stream
  output logic spec_valid,
  output logic [2:0] spec_chan,
  output logic [4:0] spec_idx,
  output logic [15:0] spec_mag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spec_valid = 1'b0;
    spec_chan = 3'h0;
    spec_idx = 5'h00;
    spec_mag = 16'h0000;
  end
  // dc, fundamental, then every harmonic up to 31 in order
  task automatic frame(input logic [2:0] c, input logic [15:0] f, input logic [15:0] h2, input logic [15:0] h31);
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      spec_valid <= 1'b1;
      spec_chan <= c;
      spec_idx <= 5'(i);
      spec_mag <= (i == 1) ? f : (i == 2) ? h2 : (i == 31) ? h31 : 16'h0000;
    end
    @(posedge pclk);
    // idle lines carry junk, not the last sample
    spec_valid <= 1'b0;
    spec_idx <= 5'h15;
    spec_mag <= ~spec_mag;
  endtask : frame
endmodule : hdm_spec_src

// ==== dv/hdm_top_tb.sv ====
// self-checking bench for the distortion monitor
module hdm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hdm_pkg::*;
  localparam int MS = 20;
  localparam logic [15:0] FUND = 16'h03E8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, block_in, evt_valid, evt_on, irq, ev_on, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, evt_stamp, rd;
  logic [3:0] pstrb, evt_id, ev_id;
  logic spec_valid;
  logic [2:0] spec_chan, set_sel, ph, r1, r2;
  logic [4:0] spec_idx;
  logic [15:0] spec_mag;
  logic [31:0] ev_stamp, ev_ms;
  int cyc = 0;
  int errors = 0;
  int num_checks = 0;

  always #4 pclk = ~pclk;

  hdm_top #(.MAG_W(16), .MS_CYC(MS)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spec_valid(spec_valid), .spec_chan(spec_chan), .spec_idx(spec_idx), .spec_mag(spec_mag),
    .set_sel(set_sel), .block_in(block_in), .phase_distortion_outputs(ph),
    .residual_one_distortion_outputs(r1), .residual_two_distortion_outputs(r2),
    .evt_valid(evt_valid), .evt_id(evt_id), .evt_on(evt_on), .evt_stamp(evt_stamp), .irq(irq)
  );

  hdm_spec_src src (
    .pclk(pclk), .spec_valid(spec_valid), .spec_chan(spec_chan), .spec_idx(spec_idx), .spec_mag(spec_mag)
  );

  // latest event seen on the event stream, with the millisecond it should carry
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      cyc <= cyc + 1;
    end
    if (evt_valid === 1'b1) begin
      ev_id <= evt_id;
      ev_on <= evt_on;
      ev_stamp <= evt_stamp;
      ev_ms <= 32'((cyc - 1) / MS);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic frm(input logic [2:0] c, input logic [15:0] h2, input logic [15:0] h31);
    src.frame(c, FUND, h2, h31);
    repeat (6) @(posedge pclk);
    #1;
  endtask : frm

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd, 32'h0000000E);
    apb(1'b0, 12'h17C, 32'h0, 4'hF);
    chk(rd, 32'h006403E8);
    apb(1'b0, 12'h020, 32'h0, 4'hF);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h100, 32'h0, 4'h3);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h100, 32'h0, 4'hF);
    chk(rd, 32'h006403E8);
  endtask : t_regs

  task automatic t_pick;
    apb(1'b1, 12'h100, 32'h000203E8, 4'hF);
    apb(1'b1, 12'h00C, 32'h1, 4'hF);
    apb(1'b1, 12'h000, 32'h1E, 4'hF);
    frm(3'h1, 16'h003C, 16'h0050);
    chk(32'(ph), 32'h0);
    frm(3'h1, 16'h003C, 16'h0051);
    chk(32'(ph), 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk({27'h0, ev_id, ev_on}, 32'h1);
    chk(ev_stamp, ev_ms);
    repeat (3 * MS + 10) @(posedge pclk);
    chk(32'(ph), 32'h3);
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk(rd, 32'h2);
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    chk(rd, 32'h00000403);
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    chk(rd, 32'h0);
    frm(3'h1, 16'h0000, 16'h0062);
    chk(32'(ph), 32'h3);
    frm(3'h1, 16'h0000, 16'h0060);
    chk(32'(ph), 32'h0);
    chk({27'h0, ev_id, ev_on}, 32'h2);
    apb(1'b1, 12'h000, 32'h1E, 4'hF);
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk(rd, 32'h0);
  endtask : t_pick

  task automatic t_power;
    apb(1'b1, 12'h000, 32'h0F, 4'hF);
    frm(3'h3, 16'h013C, 16'h0000);
    chk(32'(r1), 32'h0);
    frm(3'h3, 16'h013D, 16'h0000);
    chk(32'(r1), 32'h1);
    frm(3'h0, 16'h013D, 16'h0000);
    chk(32'(ph), 32'h1);
    frm(3'h0, 16'h0000, 16'h0000);
    frm(3'h3, 16'h0000, 16'h0000);
    chk(32'({ph, r1}), 32'h0);
    apb(1'b1, 12'h000, 32'h0E, 4'hF);
  endtask : t_power

  task automatic t_block;
    @(posedge pclk);
    block_in <= 1'b1;
    frm(3'h4, 16'h00C8, 16'h0000);
    chk(32'(r2), 32'h4);
    @(posedge pclk);
    block_in <= 1'b0;
    frm(3'h4, 16'h00C8, 16'h0000);
    chk(32'(r2), 32'h4);
    frm(3'h4, 16'h0000, 16'h0000);
    chk(32'(r2), 32'h0);
    // blocking raised after start: start drops, blocked takes over
    frm(3'h4, 16'h00C8, 16'h0000);
    chk(32'(r2), 32'h1);
    @(posedge pclk);
    block_in <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(r2), 32'h4);
    @(posedge pclk);
    block_in <= 1'b0;
    frm(3'h4, 16'h0000, 16'h0000);
    chk(32'(r2), 32'h0);
  endtask : t_block

  task automatic t_sets;
    apb(1'b1, 12'h130, 32'h000207D0, 4'hF);
    @(posedge pclk);
    set_sel <= 3'h3;
    frm(3'h0, 16'h0096, 16'h0000);
    chk(32'(ph), 32'h0);
    @(posedge pclk);
    set_sel <= 3'h0;
    frm(3'h0, 16'h0096, 16'h0000);
    chk(32'(ph), 32'h1);
    frm(3'h0, 16'h0000, 16'h0000);
  endtask : t_sets

  task automatic t_enable;
    apb(1'b1, 12'h000, 32'h0C, 4'hF);
    frm(3'h2, 16'h01F4, 16'h0000);
    chk(32'(ph), 32'h0);
    apb(1'b1, 12'h000, 32'h0E, 4'hF);
    // the flag stored while disabled raises start at once, before any alarm delay
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(ph), 32'h1);
  endtask : t_enable

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    set_sel = 3'h0;
    block_in = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pick();
    t_power();
    t_block();
    t_sets();
    t_enable();
    finish_test();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    finish_test();
  end
endmodule : hdm_top_tb
